// [wwd_pkg.sv]
// constants shared by the window watchdog files
package wwd_pkg;
	// ************************************************
	// clock rate
	// ************************************************
	localparam int unsigned CLK_HZ = 20000000;
	// ************************************************
	// window bounds in time-base clocks
	// ************************************************
	localparam logic [7:0] LO_OK = 8'h4f; // 79 when ok
	localparam logic [7:0] LO_NOK = 8'h50; // 80 when not ok
	localparam logic [7:0] HI_NOK = 8'ha9; // 169 when not ok
	localparam logic [7:0] HI_OK = 8'haa; // 170 when ok
	localparam logic [7:0] DROP_CNT = 8'hfa; // 250 dropout
	localparam logic [7:0] ONE_CNT = 8'h01;
	localparam logic [7:0] ZERO_CNT = 8'h00;
	// ************************************************
	// up/down counter range
	// ************************************************
	localparam logic [1:0] UD_MIN = 2'h0;
	localparam logic [1:0] UD_MAX = 2'h3;
	localparam logic [1:0] UD_STEP = 2'h1;
	// ************************************************
	// supply debounce and reset delay
	// ************************************************
	localparam int unsigned DEBOUNCE_US = 10;
	localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_US * CLK_HZ + 999999)
		/ 1000000;
	localparam int unsigned RST_DELAY_US = 1000;
	// scale the clock first so the product stays inside 32 bits
	localparam int unsigned RST_DELAY_CYC = RST_DELAY_US
		* (CLK_HZ / 1000000);
	localparam int unsigned CW = 16; // width of delay counters
	// ************************************************
	// supervisor states
	// ************************************************
	typedef enum logic [2:0] {
		SUP_IDLE = 3'h1,
		SUP_DEB = 3'h2,
		SUP_DLY = 3'h4
	} wwd_sup_t;
endpackage

// [wwd_supply.sv]
// supply fault debounce and retriggerable reset delay
`timescale 1ns/1ns
module wwd_supply
	import wwd_pkg::*;
#(
	parameter int unsigned DELAY_CYC = RST_DELAY_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// over/undervoltage level, high while out of range
	input wire logic volt_fault_i,
	// reset outputs
	output logic rst_active_o,
	output logic rst_active_n_o
);
	localparam logic [CW-1:0] DEB_MAX = CW'(DEBOUNCE_CYC - 1);
	localparam logic [CW-1:0] DLY_MAX = CW'(DELAY_CYC - 1);
	localparam logic [CW-1:0] CNT_ZERO = '0;
	localparam logic [CW-1:0] CNT_ONE = CW'(1);

	wwd_sup_t state_r;
	logic [CW-1:0] deb_r;
	logic [CW-1:0] dly_r;
	logic deb_ok;
	// debounce counter reaches full time while fault still present
	assign deb_ok = volt_fault_i && (deb_r == DEB_MAX);

	// debounce counter, restarts whenever the fault level drops
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			deb_r <= CNT_ZERO;
		end else if (!volt_fault_i || deb_ok) begin
			deb_r <= CNT_ZERO;
		end else begin
			deb_r <= deb_r + CNT_ONE;
		end
	end

	// state and delay counter
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r <= SUP_DLY;
			dly_r <= CNT_ZERO;
		end else begin
			unique case (state_r)
				SUP_IDLE: begin
					// late confirmation still starts delay
					if (deb_ok) begin
						state_r <= SUP_DLY;
						dly_r <= CNT_ZERO;
					end else if (volt_fault_i) begin
						state_r <= SUP_DEB;
					end
				end
				SUP_DEB: begin
					if (!volt_fault_i) begin
						state_r <= SUP_IDLE;
					end else if (deb_ok) begin
						state_r <= SUP_DLY;
						dly_r <= CNT_ZERO;
					end
				end
				SUP_DLY: begin
					if (deb_ok) begin
						dly_r <= CNT_ZERO;
					end else if (dly_r == DLY_MAX) begin
						state_r <= SUP_IDLE;
					end else begin
						dly_r <= dly_r + CNT_ONE;
					end
				end
				default: state_r <= SUP_DLY;
			endcase
		end
	end

	// registered reset outputs, held through debounce-confirmed delay
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rst_active_o <= 1'b1;
			rst_active_n_o <= 1'b0;
		end else begin
			rst_active_o <= (state_r == SUP_DLY) || deb_ok;
			rst_active_n_o <= !((state_r == SUP_DLY) || deb_ok);
		end
	end

	short_pulse_a: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		(state_r == SUP_IDLE) ##1 (state_r == SUP_DEB) && !volt_fault_i
		|=> !rst_active_o)
		else $error("short supply pulse raised reset");
	delay_retrig_a: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		(state_r == SUP_DLY) && deb_ok |=> (dly_r == CNT_ZERO) &&
		(state_r == SUP_DLY))
		else $error("reset delay not retriggered");
endmodule

// [wwd_top.sv]
// window watchdog with up/down judge counter and hysteresis
//
// What this block does
// - trigger edge clears period, clocks up/down counter
// - up/down counter saturates between zero and three
// - good trigger counts up, bad counts down
// - count three sets ok flag, releases enable
// - count down to zero clears ok flag
// - 250 clocks without edge clears counter
// - missing trigger also clears ok flag
// - ok flag shifts window bounds by one
// - supply reset clears watchdog to initial state
// - power-up starts at zero with fault
// - period inside window good, else bad
// - below 79 or 80 clocks too fast
// - above 169 or 170 clocks too slow
// - short supply pulse ignored, long starts delay
// - pulse during delay starts second delay
`timescale 1ns/1ns
module wwd_top
	import wwd_pkg::*;
#(
	parameter int unsigned RST_DELAY = RST_DELAY_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// time base and trigger
	input wire logic rc_timebase_input_i,
	input wire logic trigger_input_i,
	// supply monitor level
	input wire logic volt_fault_i,
	// watchdog status
	output logic window_ok_flag_o,
	output logic wd_fault_o,
	output logic [1:0] judge_count_o,
	// open-collector enable: value and drive enable
	output logic ok_enable_output_o,
	output logic ok_enable_output_oe_o,
	// supply resets
	output logic pos_reset_o,
	output logic neg_reset_n_o
);
	// ************************************************
	// supply supervisor
	// ************************************************
	logic sup_rst;
	logic sup_rst_n;
	wwd_supply #(
		.DELAY_CYC(RST_DELAY)
	) u_supply (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.volt_fault_i(volt_fault_i),
		.rst_active_o(sup_rst),
		.rst_active_n_o(sup_rst_n)
	);

	// ************************************************
	// time-base tick and trigger sampling
	// ************************************************
	logic rc_prev_r;
	logic tick;
	logic trig_s1_r;
	logic trig_s2_r;
	logic trig_prev_r;
	logic trig_edge;

	// rising edge of rc clock gives one-cycle tick
	assign tick = rc_timebase_input_i && !rc_prev_r;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rc_prev_r <= 1'b0;
		end else begin
			rc_prev_r <= rc_timebase_input_i;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			trig_s1_r <= 1'b0;
			trig_s2_r <= 1'b0;
			trig_prev_r <= 1'b0;
		end else if (tick) begin
			trig_s1_r <= trigger_input_i;
			trig_s2_r <= trig_s1_r;
			trig_prev_r <= trig_s2_r;
		end
	end

	assign trig_edge = tick && trig_s2_r && !trig_prev_r;

	// ************************************************
	// period judge
	// ************************************************
	logic [7:0] period_r;
	logic [1:0] ud_r;
	logic ok_r;
	logic [7:0] lo_bound;
	logic [7:0] hi_bound;
	logic [7:0] period_now;
	logic good;
	logic missing;

	assign lo_bound = ok_r ? LO_OK : LO_NOK;
	assign hi_bound = ok_r ? HI_OK : HI_NOK;
	assign period_now = period_r + ONE_CNT;
	assign good = (period_now >= lo_bound) && (period_now <= hi_bound);
	assign missing = (period_r == DROP_CNT);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			period_r <= ZERO_CNT;
		end else if (sup_rst) begin
			period_r <= ZERO_CNT; // supply reset restarts
		end else if (trig_edge) begin
			period_r <= ZERO_CNT;
		end else if (tick && !missing) begin
			period_r <= period_r + ONE_CNT;
		end
	end

	// edge clocks up/down counter, saturating step
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ud_r <= UD_MIN; // start at zero
		end else if (sup_rst || missing) begin
			ud_r <= UD_MIN; // cleared directly
		end else if (trig_edge) begin
			if (good && ud_r != UD_MAX) begin
				ud_r <= ud_r + UD_STEP;
			end else if (!good && ud_r != UD_MIN) begin
				ud_r <= ud_r - UD_STEP;
			end
		end
	end

	// ok flip-flop set at three, cleared at zero
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ok_r <= 1'b0;
		end else if (sup_rst || missing) begin
			ok_r <= 1'b0;
		end else if (ud_r == UD_MAX) begin
			ok_r <= 1'b1;
		end else if (ud_r == UD_MIN) begin
			ok_r <= 1'b0;
		end
	end

	// ************************************************
	// registered outputs
	// ************************************************
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			window_ok_flag_o <= 1'b0;
			wd_fault_o <= 1'b1; // fault shown at power-up
			judge_count_o <= UD_MIN;
			ok_enable_output_o <= 1'b0;
			ok_enable_output_oe_o <= 1'b1;
			pos_reset_o <= 1'b1;
			neg_reset_n_o <= 1'b0;
		end else begin
			window_ok_flag_o <= ok_r;
			wd_fault_o <= !ok_r;
			judge_count_o <= ud_r;
			ok_enable_output_o <= 1'b0; // pin only ever pulled low
			ok_enable_output_oe_o <= !ok_r;
			pos_reset_o <= sup_rst;
			neg_reset_n_o <= sup_rst_n;
		end
	end

	// ************************************************
	// checks
	// ************************************************
	// counter range
	ud_range_a: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		trig_edge && (ud_r == UD_MAX) && good && !sup_rst && !missing
		|=> ud_r == UD_MAX)
		else $error("up/down counter passed three");
	good_step_a: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		trig_edge && good && (ud_r != UD_MAX) && !sup_rst && !missing
		|=> ud_r == $past(ud_r) + UD_STEP)
		else $error("good trigger did not count up");
	bad_step_a: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		trig_edge && !good && (ud_r != UD_MIN) && !sup_rst && !missing
		|=> ud_r == $past(ud_r) - UD_STEP)
		else $error("bad trigger did not count down");
	ok_set_a: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		(ud_r == UD_MAX) && !sup_rst && !missing
		|=> ok_r ##1 !ok_enable_output_oe_o)
		else $error("count three did not release enable");
	ok_clear_a: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		(ud_r == UD_MIN) |=> !ok_r ##1 ok_enable_output_oe_o)
		else $error("count zero left ok set");
	drop_clear_a: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		missing |=> (ud_r == UD_MIN) && !ok_r)
		else $error("dropout did not clear watchdog");
	window_shift_a: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		trig_edge && ok_r && (period_now == LO_OK) && !sup_rst
		&& (ud_r == UD_MAX) |=> ud_r == UD_MAX)
		else $error("ok window not widened");
	too_fast_a: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		trig_edge && (period_now < LO_OK) && !sup_rst
		|=> ud_r == (($past(ud_r) == UD_MIN) ? UD_MIN
		: $past(ud_r) - UD_STEP))
		else $error("too fast trigger not counted down");
	too_slow_a: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		trig_edge && (period_now > HI_OK) && !sup_rst && !missing
		|=> ud_r == (($past(ud_r) == UD_MIN) ? UD_MIN
		: $past(ud_r) - UD_STEP))
		else $error("too slow trigger not counted down");
	period_clr_a: assert property (@(posedge clk_i)
		disable iff (sys_rst_i)
		trig_edge |=> period_r == ZERO_CNT)
		else $error("edge did not restart period");
endmodule

// [wwd_mcu_model.sv]
// controller model: rc time base and periodic trigger for the watchdog
`timescale 1ns/1ns
module wwd_mcu_model (
	// clock
	input wire logic clk_i,
	// ticks between trigger edges, zero stops the trigger
	input wire logic [7:0] period_i,
	// time base and trigger
	output logic rc_o,
	output logic trig_o,
	// number of trigger edges sent
	output logic [7:0] sent_o
);
	logic [1:0] div_r;
	logic [7:0] gap_r;
	// quiet start so the watchdog sees defined levels at time zero
	initial begin
		div_r = 2'h0;
		gap_r = 8'h00;
		rc_o = 1'b0;
		trig_o = 1'b0;
		sent_o = 8'h00;
	end
	// time base of four clocks, trigger moved only on its rising edge
	// steady trigger rate
	always @(negedge clk_i) begin
		div_r <= div_r + 2'h1;
		rc_o <= div_r[1];
		if (div_r == 2'h2) begin
			if (period_i != 8'h00 && gap_r + 8'h01 >= period_i) begin
				trig_o <= 1'b1;
				gap_r <= 8'h00;
				sent_o <= sent_o + 8'h01;
			end else begin
				gap_r <= gap_r + 8'h01; // wraps while stopped
				if (gap_r == 8'h01) begin
					trig_o <= 1'b0; // high for two ticks
				end
			end
		end
	end
endmodule

// [wwd_top_tb_top.sv]
// self-checking bench for the window watchdog
`timescale 1ns/1ns
module wwd_top_tb_top
	import wwd_pkg::*;
;
	localparam int unsigned DLY = 400; // shortened reset delay
	localparam int LIMIT = 40000; // cycle ceiling of the whole run
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic volt_fault_i = 1'b0;
	logic [7:0] period_r = 8'h64;
	logic rc, trig, ok, fault, oe, en, pres, nres_n;
	logic [1:0] cnt;
	logic [7:0] sent;
	int errors = 0;
	int checks_done = 0;
	int cycles = 0;
	// ************************************************
	// clock, design and controller model
	// ************************************************
	always #25 clk_i = ~clk_i;
	wwd_top #(.RST_DELAY(DLY)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.rc_timebase_input_i(rc), .trigger_input_i(trig),
		.volt_fault_i(volt_fault_i), .window_ok_flag_o(ok),
		.wd_fault_o(fault), .judge_count_o(cnt), .ok_enable_output_o(en),
		.ok_enable_output_oe_o(oe), .pos_reset_o(pres),
		.neg_reset_n_o(nres_n));
	wwd_mcu_model u_mcu (.clk_i(clk_i), .period_i(period_r), .rc_o(rc),
		.trig_o(trig), .sent_o(sent));
	// ************************************************
	// reporting and shared checks
	// ************************************************
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: count %h expected %h", $time, got, exp);
		end
	endtask
	// status outputs against expected count and ok flag
	task automatic st(input logic [1:0] c, input logic k);
		chk2(cnt, c);
		chk1(ok, k);
		chk1(fault, ~k);
		chk1(oe, ~k);
		chk1(en, 1'b0);
	endtask
	// n trigger edges of period p ticks, then judge the status
	task automatic pulses(input logic [7:0] p, input int n,
		input logic [1:0] c, input logic k);
		logic [7:0] s;
		int t;
		period_r <= p;
		for (int i = 0; i < n; i++) begin
			s = sent;
			t = 0;
			while (sent === s && t < 1200) begin
				@(negedge clk_i);
				t++;
			end
		end
		repeat (24) @(negedge clk_i); // sync and judge latency
		st(c, k);
	endtask
	// ************************************************
	// scenarios
	// ************************************************
	task automatic s_reset();
		int t;
		st(2'h0, 1'b0);
		chk1(pres, 1'b1);
		chk1(nres_n, 1'b0);
		sys_rst_i = 1'b0;
		t = 0;
		while (pres !== 1'b0 && t < DLY + 50) begin
			@(negedge clk_i);
			t++;
		end
		chk1(t >= DLY, 1'b1);
		chk1(nres_n, 1'b1);
	endtask
	task automatic s_count();
		pulses(8'h64, 5, UD_MAX, 1'b1);
		pulses(8'h64, 2, UD_MAX, 1'b1);
		pulses(8'h3c, 1, 2'h2, 1'b1);
		pulses(8'h64, 1, UD_MAX, 1'b1);
	endtask
	task automatic s_hyst_ok();
		pulses(LO_OK, 1, UD_MAX, 1'b1);
		pulses(HI_OK, 1, UD_MAX, 1'b1);
		pulses(LO_OK - ONE_CNT, 1, 2'h2, 1'b1);
		pulses(8'h64, 1, UD_MAX, 1'b1);
		pulses(HI_OK + ONE_CNT, 1, 2'h2, 1'b1);
	endtask
	task automatic s_down();
		pulses(8'h3c, 2, UD_MIN, 1'b0);
		pulses(8'h3c, 1, UD_MIN, 1'b0);
	endtask
	task automatic s_hyst_nok();
		pulses(LO_NOK, 1, 2'h1, 1'b0);
		pulses(LO_OK, 1, UD_MIN, 1'b0);
		pulses(HI_NOK, 1, 2'h1, 1'b0);
		pulses(HI_OK, 1, UD_MIN, 1'b0);
	endtask
	task automatic s_drop();
		pulses(8'h64, 4, UD_MAX, 1'b1);
		period_r <= 8'h00;
		repeat (940) @(negedge clk_i); // about 240 ticks since the edge
		st(UD_MAX, 1'b1);
		repeat (100) @(negedge clk_i);
		st(UD_MIN, 1'b0);
	endtask
	task automatic s_supply();
		int hi;
		hi = 0;
		volt_fault_i = 1'b1;
		repeat (DEBOUNCE_CYC / 2 + 20) begin
			@(negedge clk_i);
			if (hi == DEBOUNCE_CYC / 2) volt_fault_i = 1'b0;
			hi += (pres !== 1'b0) ? 1000 : 1;
		end
		chk1(hi == DEBOUNCE_CYC / 2 + 20, 1'b1);
		pulses(8'h64, 5, UD_MAX, 1'b1);
		volt_fault_i = 1'b1;
		repeat (DEBOUNCE_CYC + 100) @(negedge clk_i);
		chk1(pres, 1'b1);
		chk1(nres_n, 1'b0);
		st(UD_MIN, 1'b0);
		volt_fault_i = 1'b0;
		repeat (5) @(negedge clk_i);
		volt_fault_i = 1'b1;
		repeat (DEBOUNCE_CYC + 100) @(negedge clk_i);
		volt_fault_i = 1'b0;
		repeat (200) @(negedge clk_i); // first delay alone ends earlier
		chk1(pres, 1'b1);
		repeat (DLY) @(negedge clk_i);
		chk1(pres, 1'b0);
	endtask
	// cycle ceiling against a hung run
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			$display("Error at %0t: cycle limit reached", $time);
			end_sim();
		end
	end
	// main sequence, reset held for eight cycles
	initial begin
		repeat (8) @(negedge clk_i);
		s_reset();
		s_count();
		s_hyst_ok();
		s_down();
		s_hyst_nok();
		s_drop();
		s_supply();
		end_sim();
	end
endmodule
